// ### design/adc_post.v
// post-conversion processing: low-latency bypass, fine gain, dc trim loop
// assumes raw samples arrive signed twos complement, one per clk_i edge,
// and a wishbone classic master for configuration
//
// How it works
// - bypass path delays raw sample exactly 10 cycles
// - processing path adds two cycles of latency
// - reset gives bypass mode, gain and trim off
// - leaving bypass enables gain at the written code, 0dB from reset
// - gain code steps 0.5dB from 0 to 6dB
// - full-scale shrinks as gain rises, table values
// - gain stays off while still in bypass
// - trim corrects offsets up to 10mV equivalent
// - enabled loop corrects every cycle once bypass is left, updates every cycle unless held
// - time constant counted in sample clock cycles
// - code 0..11 gives 1M..2G cycles, 12..15 reserved
// - hold freezes estimate, still applied every cycle
// - trim disabled after reset
// - output word 14 or 12 bits by parameter
`timescale 1ns/1ps
`include "adc_post_defines.vh"

module adc_post #(
  parameter DW = 14
) (
  input wire clk_i,
  input wire rst_i,
  input wire [DW-1:0] raw_i,
  output reg [DW-1:0] dout_o,
  input wire [3:0] adr_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  input wire we_i,
  input wire [3:0] sel_i,
  input wire cyc_i,
  input wire stb_i,
  output reg ack_o,
  output reg bypass_o
);

  // ==========================================================
  // constants
  localparam FW = 16;
  localparam ACCW = DW + 32;
  localparam signed [DW-1:0] POS_FS = {1'b0, {(DW-1){1'b1}}};
  localparam signed [DW-1:0] NEG_FS = {1'b1, {(DW-1){1'b0}}};
  // offset limit in codes: 10mV of 2Vpp full scale
  localparam integer OFS_LIM_I = (`OFFSET_LIMIT_MV * (1 << DW)) / `FULL_SCALE_MV;
  localparam signed [DW:0] OFS_LIM = OFS_LIM_I[DW:0];
  localparam integer LAT_B = `BYPASS_LATENCY;
  localparam integer LAT_P = `BYPASS_LATENCY - `PROC_EXTRA_LATENCY;
  // shift base: code 0 averages over 2^20 cycles
  localparam [5:0] TC_BASE = `TC_SHIFT_BASE;

  // ==========================================================
  // registers
  reg bypass_dis_q;
  reg trim_en_q;
  reg trim_hold_q;
  reg [`GAIN_CODE_W-1:0] gain_code_q;
  reg [`TC_CODE_W-1:0] tc_code_q;
  reg [FW-1:0] gain_mult;
  wire bus_req;
  wire wr_ctrl;
  reg [31:0] rd_d;

  assign bus_req = cyc_i & stb_i & ~ack_o;
  assign wr_ctrl = bus_req & we_i & sel_i[0];

  // gain lookup, q2.14: 10^(g/20), 0.5dB steps
  always @* begin
    case (gain_code_q)
      4'h0: gain_mult = 16'h4000;
      4'h1: gain_mult = 16'h43D1;
      4'h2: gain_mult = 16'h47DC;
      4'h3: gain_mult = 16'h4C24;
      4'h4: gain_mult = 16'h50AE;
      4'h5: gain_mult = 16'h557D;
      4'h6: gain_mult = 16'h5A97;
      4'h7: gain_mult = 16'h6000;
      4'h8: gain_mult = 16'h65AC;
      4'h9: gain_mult = 16'h6BA7;
      4'hA: gain_mult = 16'h71F7;
      4'hB: gain_mult = 16'h7898;
      default: gain_mult = 16'h7FB2;
    endcase
  end

  // ==========================================================
  // wishbone slave, answers one cycle after the request
  always @(posedge clk_i) begin
    if (rst_i) begin
      bypass_dis_q <= 1'b0;
      trim_en_q <= 1'b0;
      trim_hold_q <= 1'b0;
      gain_code_q <= `GAIN_CODE_RST;
      tc_code_q <= `TC_CODE_RST;
    end else begin
      // write data is taken at the same edge that raises ack
      if (wr_ctrl) begin
        if (adr_i == `REG_CTRL_ADDR) begin
          // leaving bypass with gain code left at reset value gives 0dB
          bypass_dis_q <= dat_i[`CTRL_BYPASS_DIS_BIT];
          trim_en_q <= dat_i[`CTRL_TRIM_EN_BIT];
          trim_hold_q <= dat_i[`CTRL_TRIM_HOLD_BIT];
        end else if (adr_i == `REG_GAIN_ADDR) begin
          // codes above 6dB clamp to 6dB
          if (dat_i[`GAIN_CODE_W-1:0] > `GAIN_CODE_MAX) begin
            gain_code_q <= `GAIN_CODE_MAX;
          end else begin
            gain_code_q <= dat_i[`GAIN_CODE_W-1:0];
          end
        end else if (adr_i == `REG_TC_ADDR) begin
          // reserved codes are the writer's fault; clamp keeps the shift bounded
          if (dat_i[`TC_CODE_W-1:0] > `TC_CODE_MAX) begin
            tc_code_q <= `TC_CODE_MAX;
          end else begin
            tc_code_q <= dat_i[`TC_CODE_W-1:0];
          end
        end
      end
    end
  end

  // ==========================================================
  // bus handshake: ack is a one-cycle pulse, read data stands with it
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      // ack masks the request so a strobe still high in the ack cycle is not taken twice
      ack_o <= bus_req;
      dat_o <= rd_d;
    end
  end

  reg signed [DW:0] ofs_est;

  // unmapped addresses read as zero
  always @* begin
    rd_d = 32'h0000_0000;
    if (adr_i == `REG_CTRL_ADDR) begin
      rd_d[`CTRL_BYPASS_DIS_BIT] = bypass_dis_q;
      rd_d[`CTRL_TRIM_EN_BIT] = trim_en_q;
      rd_d[`CTRL_TRIM_HOLD_BIT] = trim_hold_q;
    end else if (adr_i == `REG_GAIN_ADDR) begin
      rd_d[`GAIN_CODE_W-1:0] = gain_code_q;
    end else if (adr_i == `REG_TC_ADDR) begin
      rd_d[`TC_CODE_W-1:0] = tc_code_q;
    end else if (adr_i == `REG_STAT_ADDR) begin
      rd_d[DW:0] = ofs_est;
    end
  end

  // ==========================================================
  // bypass delay line: nine stages, the output register makes the tenth
  // stages hold zero after reset so no stale word reaches the pins
  reg [DW-1:0] byp_q [0:LAT_B-2];
  genvar gi;
  generate
    for (gi = 0; gi < LAT_B - 1; gi = gi + 1) begin : g_byp
      if (gi == 0) begin : g_head
        always @(posedge clk_i) begin
          if (rst_i) begin
            byp_q[gi] <= {DW{1'b0}};
          end else begin
            byp_q[gi] <= raw_i;
          end
        end
      end else begin : g_tail
        always @(posedge clk_i) begin
          if (rst_i) begin
            byp_q[gi] <= {DW{1'b0}};
          end else begin
            byp_q[gi] <= byp_q[gi-1];
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // processing path: tap after nine cycles, then gain, trim and output
  // registers, 12 cycles in all, two more than the bypass
  // limitation: the loop settles over millions of cycles; code 0 is quickest
  wire signed [DW-1:0] pre_s = byp_q[LAT_P];
  // gain multiplier is q2.14, so 0dB passes the sample unchanged
  wire signed [DW+FW:0] prod = pre_s * $signed({1'b0, gain_mult});
  // dropping the 14 fraction bits leaves headroom for 6dB
  wire signed [DW+2:0] scaled = $signed(prod[DW+FW:FW-2]);

  reg signed [DW-1:0] gain_d;
  reg signed [DW-1:0] gain_q;
  reg signed [DW-1:0] corr_d;
  reg signed [DW-1:0] corr_q;
  reg signed [ACCW-1:0] acc_d;
  reg signed [ACCW-1:0] acc_q;
  reg signed [ACCW-1:0] est_full;

  wire signed [DW+1:0] diff = $signed({gain_q[DW-1], gain_q}) - ofs_est;
  wire [5:0] shamt = TC_BASE + {2'b00, tc_code_q};
  // trim enable is ignored while the bypass is selected
  wire trim_on = trim_en_q & bypass_dis_q;

  // ==========================================================
  // offset estimate, accumulator over 2^(20+code) cycles
  // clamped at full width so a large estimate cannot wrap back into range
  always @* begin
    est_full = acc_q >>> shamt;
    if (est_full > OFS_LIM) begin
      ofs_est = OFS_LIM;
    end else if (est_full < -OFS_LIM) begin
      ofs_est = -OFS_LIM;
    end else begin
      ofs_est = est_full[DW:0];
    end
  end

  // ==========================================================
  // gain stage, saturating at the full-scale codes
  always @* begin
    if (scaled > $signed({3'b000, POS_FS})) begin
      gain_d = POS_FS;
    end else if (scaled < $signed({3'b111, NEG_FS})) begin
      gain_d = NEG_FS;
    end else begin
      gain_d = scaled[DW-1:0];
    end
  end

  // gain only reaches the output once bypass is left
  always @(posedge clk_i) begin
    if (rst_i) begin
      gain_q <= {DW{1'b0}};
    end else begin
      gain_q <= gain_d;
    end
  end

  // ==========================================================
  // trim loop: leaky integrator, cleared whenever trim is off
  // the leak equals the estimate, so the loop settles at the input mean
  // worst case the sum stays below 2^45, inside the accumulator
  always @* begin
    acc_d = acc_q;
    if (!trim_on) begin
      acc_d = {ACCW{1'b0}};
    end else if (!trim_hold_q) begin
      acc_d = acc_q + {{(ACCW-DW){gain_q[DW-1]}}, gain_q} - est_full;
    end
  end

  always @* begin
    corr_d = gain_q;
    if (trim_on) begin
      // a held estimate is still subtracted every cycle
      if (diff > $signed({2'b00, POS_FS})) begin
        corr_d = POS_FS;
      end else if (diff < $signed({2'b11, NEG_FS})) begin
        corr_d = NEG_FS;
      end else begin
        corr_d = diff[DW-1:0];
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      acc_q <= {ACCW{1'b0}};
      corr_q <= {DW{1'b0}};
    end else begin
      acc_q <= acc_d;
      corr_q <= corr_d;
    end
  end

  // ==========================================================
  // output register, straight to the pins
  always @(posedge clk_i) begin
    if (rst_i) begin
      dout_o <= {DW{1'b0}};
      bypass_o <= 1'b1;
    end else begin
      bypass_o <= ~bypass_dis_q;
      if (bypass_dis_q) begin
        dout_o <= corr_q;
      end else begin
        dout_o <= byp_q[LAT_B-2];
      end
    end
  end

endmodule

// ### design/adc_post_defines.vh
// constants for the converter post-processing path
// assumes inclusion by design/adc_post.v only
`ifndef ADC_POST_DEFINES_VH
`define ADC_POST_DEFINES_VH

// ==========================================================
// register map (word aligned, 32-bit wishbone)
`define REG_CTRL_ADDR 4'h0
`define REG_GAIN_ADDR 4'h4
`define REG_TC_ADDR 4'h8
`define REG_STAT_ADDR 4'hC

// ==========================================================
// control fields
`define CTRL_BYPASS_DIS_BIT 0
`define CTRL_TRIM_EN_BIT 1
`define CTRL_TRIM_HOLD_BIT 2
`define GAIN_CODE_W 4
`define GAIN_CODE_MAX 4'hC
`define TC_CODE_W 4
`define TC_CODE_MAX 4'hB
`define TC_SHIFT_BASE 20

// ==========================================================
// latency and reset values
`define BYPASS_LATENCY 10
`define PROC_EXTRA_LATENCY 2
`define GAIN_CODE_RST 4'h0
`define TC_CODE_RST 4'h0
`define OFFSET_LIMIT_MV 10
`define FULL_SCALE_MV 2000

`endif

// ### testbench/adc_post_assertions.sv
// assertions on the ports of adc_post
// assumes the bind below reaches every adc_post instance
`timescale 1ns/1ps
module adc_post_chk #(parameter DW = 14) (
  input clk_i,
  input rst_i,
  input [DW-1:0] raw_i,
  input [DW-1:0] dout_o,
  input [3:0] adr_i,
  input [31:0] dat_i,
  input [31:0] dat_o,
  input we_i,
  input [3:0] sel_i,
  input cyc_i,
  input stb_i,
  input ack_o,
  input bypass_o
);
  // ==========
  // helpers: the delay line holds reset zeros for a while after reset
  logic [3:0] up_q;
  always @(posedge clk_i) up_q <= rst_i ? 4'h0 : (up_q == 4'hF ? up_q : up_q + 4'h1);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req; cyc_i && stb_i && !ack_o; endsequence
  sequence s_ctl; s_req ##0 we_i && sel_i[0] && adr_i == 4'h0; endsequence
  // ==========
  // properties
  a_ack_next: assert property (s_req |=> ack_o) else $error("ack late");
  a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack too long");
  a_ack_idle: assert property (!cyc_i |=> !ack_o) else $error("ack without cycle");
  a_reset_state: assert property ($past(rst_i) |-> bypass_o && !ack_o && dout_o == 0)
    else $error("bad state after reset");
  a_bypass_lat: assert property (up_q > 4'hC && bypass_o && $past(bypass_o, 12)
    |-> dout_o == $past(raw_i, 10)) else $error("bypass latency");
  a_bypass_off: assert property (s_ctl ##0 dat_i[0] |-> ##[1:2] !bypass_o)
    else $error("bypass not left");
  a_bypass_on: assert property (s_ctl ##0 !dat_i[0] |-> ##[1:2] bypass_o)
    else $error("bypass not entered");
  a_unmapped_rd: assert property (ack_o && !$past(we_i) && ($past(adr_i) & 4'h3) != 4'h0
    |-> dat_o == 32'h0) else $error("unmapped read not zero");
endmodule
bind adc_post adc_post_chk #(.DW(DW)) adc_post_chk_inst (.clk_i, .rst_i, .raw_i, .dout_o,
  .adr_i, .dat_i, .dat_o, .we_i, .sel_i, .cyc_i, .stb_i, .ack_o, .bypass_o);

// ### testbench/sample_sink.sv
// partner: downstream register capturing each output word
// assumes one word per clk_i edge, no back-pressure
`timescale 1ns/1ps
module sample_sink (
  input clk_i,
  input [13:0] word_i
);
  // ==========
  // capture only: a real receiver cannot stall the converter
  logic [13:0] word_q;
  always @(posedge clk_i) word_q <= word_i;
endmodule

// ### testbench/test_adc_post.sv
// self-checking bench for adc_post
// assumes adc_post, sample_sink and the checker are compiled first
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; \
  $display("wrong value at %0t got %h exp %h", $time, a, e); end end
module test_adc_post;
  logic clk_i = 0, rst_i = 1, we_i = 0, cyc_i = 0, stb_i = 0, fix = 0;
  logic [13:0] raw_i = 0, fixv = 0;
  logic [3:0] adr_i = 0, sel_i = 0;
  logic [31:0] dat_i = 0, rd;
  logic [13:0] hist [0:63];
  wire [13:0] dout_o;
  wire [31:0] dat_o;
  wire ack_o, bypass_o;
  int cnt = 0, fails = 0, tests_run = 0;
  // odd ramp step so neighbouring samples always differ
  wire [13:0] nxt = fix ? fixv : 14'((cnt + 1) * 37);
  always #12.5 clk_i = ~clk_i;
  adc_post #(.DW(14)) adc_post_inst (.clk_i, .rst_i, .raw_i, .dout_o, .adr_i, .dat_i,
    .dat_o, .we_i, .sel_i, .cyc_i, .stb_i, .ack_o, .bypass_o);
  sample_sink sample_sink_inst (.clk_i, .word_i(dout_o));
  // ==========
  // stimulus and timeout
  always @(posedge clk_i) begin
    cnt <= cnt + 1;
    raw_i <= nxt;
    hist[(cnt + 1) % 64] <= nxt;
    if (cnt > 20000) begin
      fails++;
      give_verdict;
    end
  end
  task give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
  endtask
  task rdchk(input logic [3:0] a, input logic [31:0] e);
    wb(0, a, 32'h0, 4'hF);
    `CHK(rd, e)
  endtask
  task lat(input int d);
    repeat (14) @(posedge clk_i);
    repeat (8) begin
      @(posedge clk_i);
      #1;
      `CHK(dout_o, hist[(cnt - d) % 64])
    end
  endtask
  task hold(input logic [13:0] v, input logic [13:0] e);
    fixv <= v;
    fix <= 1;
    repeat (16) @(posedge clk_i);
    #1;
    `CHK(dout_o, e)
  endtask
  // ==========
  // tests
  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    #1;
    `CHK(bypass_o, 1'b1)
    `CHK(dout_o, 14'h0)
    rdchk(4'h0, 32'h0);
    rdchk(4'h4, 32'h0);
    rdchk(4'hC, 32'h0);
    rdchk(4'h2, 32'h0);
    $display("test reset done");
    lat(10);
    wb(1, 4'h0, 32'h1, 4'h0);
    @(posedge clk_i);
    #1;
    `CHK(bypass_o, 1'b1)
    $display("test bypass done");
    wb(1, 4'h0, 32'h1, 4'hF);
    lat(12);
    `CHK(bypass_o, 1'b0)
    wb(1, 4'h8, 32'hF, 4'hF);
    rdchk(4'h8, 32'hB);
    wb(1, 4'h4, 32'hF, 4'hF);
    rdchk(4'h4, 32'hC);
    hold(14'h1F00, 14'h1FFF);
    hold(14'h2100, 14'h2000);
    $display("test gain done");
    wb(1, 4'h4, 32'h0, 4'hF);
    fixv <= 14'h1FFF;
    wb(1, 4'h0, 32'h3, 4'hF);
    wb(1, 4'h8, 32'h0, 4'hF);
    repeat (12000) @(posedge clk_i);
    wb(1, 4'h0, 32'h7, 4'hF);
    rdchk(4'hC, 32'h51);
    repeat (16) @(posedge clk_i);
    #1;
    `CHK(dout_o, 14'h1FAE)
    rdchk(4'hC, 32'h51);
    wb(1, 4'h0, 32'h1, 4'hF);
    rdchk(4'hC, 32'h0);
    fix <= 0;
    $display("test trim done");
    wb(1, 4'h0, 32'h0, 4'hF);
    lat(10);
    $display("test return done");
    give_verdict;
  end
endmodule
